// File: rtl/sifr_defines.vh
`ifndef SIFR_DEFINES_VH
`define SIFR_DEFINES_VH
`define SIFR_ADDR_W        8
`define SIFR_DATA_W        8
`define SIFR_FLAGS_ADDR    8'h95
`define SIFR_CTRL_ADDR     8'h96
`define SIFR_FLAGS_RESET   8'h00
`define SIFR_CONV_CLR_VAL  8'hef
`define SIFR_BIT_TIMER3    0
`define SIFR_BIT_PINCHG    1
`define SIFR_BIT_CONVDONE  4
`define SIFR_BIT_NVBUSY    5
`define SIFR_BIT_CONVSTART 0
`define SIFR_PINS          8
`define SIFR_PORTS         4
`endif

// File: rtl/sifr_top.v
// Functional notes
// - set conversion-done flag bit 4 on conversion end
// - writing efh clears conversion-done flag
// - setting conversion-start bit clears conversion-done
// - enabled pin change sets pin-change flag bit 1
// - writing 0 to bit 1 clears all pin flags
// - timer3 prescale reached sets flag bit 0
// - bit 5 reads nonvolatile write busy
`include "sifr_defines.vh"
module sifr_top (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire [`SIFR_ADDR_W-1:0]  addr,
  input  wire [`SIFR_DATA_W-1:0]  wdata,
  input  wire                     wr,
  input  wire                     rd,
  output reg  [`SIFR_DATA_W-1:0]  rdata,
  input  wire                     conv_done_evt,
  input  wire                     timer3_evt,
  input  wire [`SIFR_PINS-1:0]    pin_change_evt,
  input  wire [`SIFR_PINS-1:0]    pin_irq_enable,
  input  wire [`SIFR_PORTS-1:0]   port_change_evt,
  input  wire                     nv_write_busy_in,
  output reg                      conv_start_bit,
  output reg  [`SIFR_PINS-1:0]    per_pin_change_flags,
  output reg  [`SIFR_PORTS-1:0]   per_port_change_flags,
  output reg  [`SIFR_DATA_W-1:0]  interrupt_flags
);


  // address decode is shared by the write and read paths
  function hit;
    input [`SIFR_ADDR_W-1:0] a;
    input [`SIFR_ADDR_W-1:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // a zero written at a flag position asks for that flag to clear
  function bit_clear;
    input [`SIFR_DATA_W-1:0] d;
    input integer            pos;
    begin
      bit_clear = ~d[pos];
    end
  endfunction

  // sticky flag step: a set in the same cycle beats a clear
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  // places each live flag at its register position; unused bits stay zero
  function [`SIFR_DATA_W-1:0] pack_flags;
    input tmr;
    input pin;
    input conv;
    input busy;
    begin
      pack_flags                     = `SIFR_FLAGS_RESET;
      pack_flags[`SIFR_BIT_TIMER3]   = tmr;
      pack_flags[`SIFR_BIT_PINCHG]   = pin;
      pack_flags[`SIFR_BIT_CONVDONE] = conv;
      pack_flags[`SIFR_BIT_NVBUSY]   = busy;
    end
  endfunction

  wire                    wr_flags;
  wire                    wr_ctrl;
  wire                    rd_flags;
  wire                    conv_clr;
  wire                    start_set;
  wire                    pin_clr;
  wire                    timer3_clr;
  wire                    pin_evt;
  wire [`SIFR_PINS-1:0]   pin_hits;
  wire [`SIFR_PINS-1:0]   next_pin_flags;
  wire [`SIFR_PORTS-1:0]  next_port_flags;

  reg                     conv_done_flag;
  reg                     pin_change_flag;
  reg                     timer3_flag;
  reg                     next_conv_done;
  reg                     next_pin_change;
  reg                     next_timer3;
  reg  [`SIFR_DATA_W-1:0] next_flags;

  assign wr_flags   = wr && hit(addr, `SIFR_FLAGS_ADDR);
  assign wr_ctrl    = wr && hit(addr, `SIFR_CTRL_ADDR);
  assign rd_flags   = rd && hit(addr, `SIFR_FLAGS_ADDR);
  // on the flags register only the exact clear value clears conversion-done; other flags writes keep it
  assign conv_clr   = wr_flags && (wdata == `SIFR_CONV_CLR_VAL);
  assign start_set  = wr_ctrl && wdata[`SIFR_BIT_CONVSTART];
  assign pin_clr    = wr_flags && bit_clear(wdata, `SIFR_BIT_PINCHG);
  assign timer3_clr = wr_flags && bit_clear(wdata, `SIFR_BIT_TIMER3);
  // a change on a disabled pin leaves both the summary and the pin flag alone
  assign pin_hits   = pin_change_evt & pin_irq_enable;
  assign pin_evt    = |pin_hits;

  // an event landing on the clear write is kept, so software never loses one
  always @* begin
    next_conv_done = conv_done_flag;
    if (conv_done_evt) begin
      next_conv_done = 1'b1;
    end else if (conv_clr || start_set) begin
      next_conv_done = 1'b0;
    end
  end

  always @* begin
    next_pin_change = pin_change_flag;
    if (pin_evt) begin
      next_pin_change = 1'b1;
    end else if (pin_clr) begin
      next_pin_change = 1'b0;
    end
  end

  always @* begin
    next_timer3 = timer3_flag;
    if (timer3_evt) begin
      next_timer3 = 1'b1;
    end else if (timer3_clr) begin
      next_timer3 = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_flag <= 1'b0;
    end else begin
      conv_done_flag <= next_conv_done;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_flag <= 1'b0;
    end else begin
      pin_change_flag <= next_pin_change;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer3_flag <= 1'b0;
    end else begin
      timer3_flag <= next_timer3;
    end
  end

  // one summary clear empties every pin and port flag at once, except a flag whose event lands in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `SIFR_PINS; gi = gi + 1) begin : g_pin
      assign next_pin_flags[gi] = sticky(per_pin_change_flags[gi],
                                         pin_hits[gi], pin_clr);
    end
    for (gi = 0; gi < `SIFR_PORTS; gi = gi + 1) begin : g_port
      assign next_port_flags[gi] = sticky(per_port_change_flags[gi],
                                          port_change_evt[gi], pin_clr);
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_pin_change_flags <= {`SIFR_PINS{1'b0}};
    end else begin
      per_pin_change_flags <= next_pin_flags;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_port_change_flags <= {`SIFR_PORTS{1'b0}};
    end else begin
      per_port_change_flags <= next_port_flags;
    end
  end

  // start bit is a one-shot; conversion logic sees a one-cycle pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_bit <= 1'b0;
    end else begin
      conv_start_bit <= start_set;
    end
  end

  // busy is live, so it shows even while the flag bits are being cleared
  always @* begin
    next_flags = pack_flags(timer3_flag, pin_change_flag, conv_done_flag, nv_write_busy_in);
  end

  // registered copy lags the live state by one cycle to keep outputs on flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_flags <= `SIFR_FLAGS_RESET;
    end else begin
      interrupt_flags <= next_flags;
    end
  end

  // unmapped and idle reads return zero, so a stale word never lingers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `SIFR_FLAGS_RESET;
    end else if (rd_flags) begin
      rdata <= next_flags;
    end else begin
      rdata <= `SIFR_FLAGS_RESET;
    end
  end

endmodule // sifr_top

// File: test/sifr_top_properties.sv
module sifr_top_properties(input wire logic clk, rst_n, wr, rd, conv_done_evt, timer3_evt,
  nv_write_busy_in, conv_start_bit, input wire logic [7:0] addr, wdata, rdata,
  pin_change_evt, pin_irq_enable, per_pin_change_flags, interrupt_flags);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence conv_clr; wr && addr == 8'h95 && wdata == 8'hef && !conv_done_evt; endsequence
  sequence pin_hit; |(pin_change_evt & pin_irq_enable); endsequence
  sequence pin_clr_req;
    wr && addr == 8'h95 && !wdata[1] && !(|(pin_change_evt & pin_irq_enable));
  endsequence
  a_conv_set: assert property (conv_done_evt |-> ##[1:2] interrupt_flags[4])
    else $error("conv set");
  a_conv_clear: assert property (conv_clr |-> ##[1:2] !interrupt_flags[4])
    else $error("conv clear");
  a_start_clear: assert property (conv_start_bit |-> ##[1:2] !interrupt_flags[4])
    else $error("start clear");
  a_pin_set: assert property (pin_hit |-> ##[1:2] interrupt_flags[1])
    else $error("pin set");
  a_pin_clear: assert property (pin_clr_req |-> ##1 per_pin_change_flags == 8'h00)
    else $error("pin clear");
  a_timer_set: assert property (timer3_evt |-> ##[1:2] interrupt_flags[0])
    else $error("timer set");
  a_busy_show: assert property (nv_write_busy_in |-> ##[1:2] interrupt_flags[5])
    else $error("busy");
  a_reset_zero: assert property ($rose(rst_n) |-> interrupt_flags == 8'h00)
    else $error("reset");
endmodule // sifr_top_properties
bind sifr_top sifr_top_properties chk(.*);

// File: test/sifr_top_tb.sv
module sifr_top_tb;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ce = 0, te = 0, nb = 0, cs;
  logic [7:0] addr = 0, wd = 0, pe = 0, en = 8'hff, rdata, ifl, pf;
  logic [3:0] po = 0, qf;
  int fails = 0, checked = 0;
  sifr_top dut(.clk, .rst_n, .addr, .wdata(wd), .wr, .rd, .rdata, .conv_done_evt(ce),
    .timer3_evt(te), .pin_change_evt(pe), .pin_irq_enable(en), .port_change_evt(po),
    .nv_write_busy_in(nb), .conv_start_bit(cs), .per_pin_change_flags(pf),
    .per_port_change_flags(qf), .interrupt_flags(ifl));
  initial forever #2 clk = ~clk;
  task chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin fails++; $display("Error %0t got %h want %h", $time, g, e); end
  endtask
  task drv(input logic w, r, c, t, input logic [7:0] a, d, p);
    @(posedge clk); {wr, rd, ce, te, addr, wd, pe, po} <= {w, r, c, t, a, d, p, p[3:0]};
    @(posedge clk); {wr, rd, ce, te, pe, po} <= 0;
  endtask
  task rdc(input logic [7:0] e);
    drv(0, 1, 0, 0, 8'h95, 0, 0);
    #1 chk(rdata, e);
    chk(ifl, e);
  endtask
  task t_conv;
    drv(0, 0, 1, 1, 0, 0, 0); rdc(8'h11);
    drv(1, 0, 0, 0, 8'h95, 8'hef, 0); rdc(8'h01);
    drv(0, 0, 1, 0, 0, 0, 0); drv(1, 0, 0, 0, 8'h96, 8'h01, 0);
    #1 chk({7'h0, cs}, 8'h01);
    drv(1, 0, 0, 0, 8'h95, 8'hfe, 0); rdc(8'h00);
    $display("conv test done");
  endtask
  task t_pin;
    en <= 8'hfe;
    drv(0, 0, 0, 0, 0, 0, 8'h01); rdc(8'h00); chk(pf, 8'h00);
    en <= 8'hff;
    drv(0, 0, 0, 0, 0, 0, 8'h01); rdc(8'h02); chk(pf, 8'h01);
    chk({4'h0, qf}, 8'h01);
    drv(1, 0, 0, 0, 8'h95, 8'hfd, 0); rdc(8'h00); chk(pf, 0); chk({4'h0, qf}, 0);
    $display("pin test done");
  endtask
  task t_busy;
    @(posedge clk) nb <= 1;
    rdc(8'h20);
    $display("busy test done");
  endtask
  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    rdc(8'h00);
    t_conv; t_pin; t_busy;
    test_done;
  end
endmodule // sifr_top_tb
